// ==== fbsp_pkg.sv ====
// Purpose: shared constants and types for the flyback startup supervisor
// Assumes: 40 MHz system clock, 16-bit register port, word-aligned offsets
// Notes: register offsets are word indices; byte address is index * 4
package fbsp_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int PRI_OCP_BLANK_NS = 250;
  localparam logic [15:0] PRI_OCP_BLANK_CYC =
    16'((PRI_OCP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int BUS_CHECK_BLANK_NS = 1000;
  localparam logic [15:0] BUS_CHECK_BLANK_CYC =
    16'((BUS_CHECK_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int DERATE_TICK_US = 1000;
  localparam int DERATE_TICK_CYC = DERATE_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_UNIT_SHIFT = 10;
  // ****************************************************************
  // sense scaling
  // ****************************************************************
  localparam int CS_FULL_SCALE_MV = 2500;
  localparam int CS_SHORT_LIMIT_UV = 97600;
  localparam logic [11:0] CS_SHORT_LIMIT_CODE =
    12'(CS_SHORT_LIMIT_UV * 4 / CS_FULL_SCALE_MV * 1024 / 1000);
  localparam logic [15:0] CS_STEP = 16'h0010;
  localparam logic [11:0] NTC_VREF_CODE = 12'hfff;
  localparam logic [15:0] NTC_PULLUP_OHM = 16'h2710;
  localparam logic [12:0] ZCD_CLAMP_OFS = 13'h0040;
  localparam logic [15:0] ZCD_BUS_GAIN = 16'h0100;
  localparam logic [15:0] DERATE_STEP = 16'h0008;
  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [5:0] RI_CTRL = 6'h00;
  localparam logic [5:0] RI_SW_PERIOD = 6'h01;
  localparam logic [5:0] RI_STEP_DUR = 6'h02;
  localparam logic [5:0] RI_FINAL_LIMIT = 6'h03;
  localparam logic [5:0] RI_START_UV = 6'h04;
  localparam logic [5:0] RI_UV_THR = 6'h05;
  localparam logic [5:0] RI_OV_THR = 6'h06;
  localparam logic [5:0] RI_OC_THR = 6'h07;
  localparam logic [5:0] RI_OP_THR = 6'h08;
  localparam logic [5:0] RI_TIMEOUT = 6'h09;
  localparam logic [5:0] RI_UV_BLANK = 6'h0a;
  localparam logic [5:0] RI_OV_BLANK = 6'h0b;
  localparam logic [5:0] RI_OC_BLANK = 6'h0c;
  localparam logic [5:0] RI_OP_BLANK = 6'h0d;
  localparam logic [5:0] RI_NTC_HOT = 6'h0e;
  localparam logic [5:0] RI_NTC_CRIT = 6'h0f;
  localparam logic [5:0] RI_GATE_DRV = 6'h10;
  localparam logic [5:0] RI_BUS_TOL = 6'h11;
  localparam logic [5:0] RI_I_MAX = 6'h12;
  localparam logic [5:0] RI_I_MIN = 6'h13;
  localparam logic [5:0] RI_NCFG = 6'h14;
  localparam logic [5:0] RI_STATUS = 6'h14;
  localparam logic [5:0] RI_TARGET = 6'h15;
  localparam logic [5:0] RI_NTC_RES = 6'h16;
  localparam logic [5:0] RI_BUS_FB = 6'h17;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] SW_PERIOD_RST = 16'h0190;
  localparam logic [15:0] STEP_DUR_RST = 16'h0fa0;
  localparam logic [15:0] I_MAX_RST = 16'h8000;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SOFT = 3'b001, ST_CHARGE = 3'b011,
    ST_RUN = 3'b010, ST_FAULT = 3'b110
  } fbsp_state_e;
  typedef enum logic [1:0] {
    FIRST_VALLEY_MODE = 2'b00, DISCONTINUOUS_MODE = 2'b01,
    BURST_MODE = 2'b10, CONTINUOUS_CONDUCTION = 2'b11
  } fbsp_mode_e;
  typedef struct packed {
    logic ext_ot;
    logic bus_mismatch;
    logic continuous_conduction;
    logic cs_short;
    logic out_op;
    logic out_oc;
    logic out_ov;
    logic out_uv;
    logic pri_ocp;
  } fbsp_fault_s;
  typedef struct packed {
    logic [3:0] pulses;
    logic [3:0] freq_sel;
    logic [3:0] peak_sel;
  } fbsp_loop_start_s;
  typedef struct packed {
    logic [3:0] high_level;
    logic [3:0] slope;
  } fbsp_gate_drive_s;
endpackage

// ==== fbsp_top.sv ====
// Purpose: flyback soft start, hand-over and protection supervision
// Assumes: sense inputs are digitised samples synchronous to clk_sys_in
// Notes: any fault stops switching until software clears the flags

// ******************************************************************
// blanking timer
// ******************************************************************
module fbsp_blank_timer #(parameter int W = 16) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cond_in,
  input wire logic [W-1:0] limit_in,
  output logic trip_out
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic trip_nxt;
  always_comb begin
    // restart whenever the condition drops out
    cnt_nxt = '0;
    if (cond_in && cnt_r != '1) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (cond_in) begin
      cnt_nxt = cnt_r;
    end
    trip_nxt = cond_in && (cnt_r >= limit_in);
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      trip_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      trip_out <= trip_nxt;
    end
  end
  a_blank_restart: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in) !cond_in |=> (cnt_r == '0) && !trip_out)
    else $error("blanking count did not restart");
endmodule

// ******************************************************************
// top
// ******************************************************************
module fbsp_top import fbsp_pkg::*; #(
  parameter int DERATE_TICK = DERATE_TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  input wire logic [11:0] cs_sample_in,
  input wire logic [11:0] zcd_clamp_in,
  input wire logic [15:0] bus_sense_in,
  input wire logic [15:0] vout_est_in,
  input wire logic [15:0] iout_calc_in,
  input wire logic [11:0] ntc_volt_in,
  input wire logic [1:0] mode_in,
  input wire logic loop_gate_in,
  output logic gate_out,
  output logic [15:0] cur_limit_out,
  output logic loop_enable_out,
  output fbsp_loop_start_s loop_start_out,
  output fbsp_gate_drive_s gate_drive_out,
  output logic [15:0] current_target_out,
  output logic fault_out
);
  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0] cfg_r [20];
  logic [15:0] cfg_nxt [20];
  logic [5:0] idx;
  logic flt_clear;
  logic [15:0] rd_nxt;
  fbsp_state_e state_r, state_nxt;
  fbsp_fault_s flt_r, flt_nxt, flt_set;
  logic [15:0] target_r, target_nxt, r_ntc_r, r_ntc_nxt;
  logic [15:0] bus_fb_r, bus_fb_nxt;

  assign idx = addr_in[7:2];
  assign flt_clear = wr_en_in && idx == RI_CTRL && wr_data_in[CTRL_CLR_BIT];

  always_comb begin
    for (int i = 0; i < 20; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (wr_en_in && idx < RI_NCFG) begin
      cfg_nxt[idx[4:0]] = wr_data_in;
    end
    rd_nxt = 16'h0000;
    if (rd_en_in) begin
      if (idx < RI_NCFG) begin
        rd_nxt = cfg_r[idx[4:0]];
      end else if (idx == RI_STATUS) begin
        rd_nxt = {4'h0, state_r, flt_r};
      end else if (idx == RI_TARGET) begin
        rd_nxt = target_r;
      end else if (idx == RI_NTC_RES) begin
        rd_nxt = r_ntc_r;
      end else if (idx == RI_BUS_FB) begin
        rd_nxt = bus_fb_r;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 20; i++) begin
        cfg_r[i] <= CFG_RST;
      end
      cfg_r[RI_SW_PERIOD[4:0]] <= SW_PERIOD_RST;
      cfg_r[RI_STEP_DUR[4:0]] <= STEP_DUR_RST;
      cfg_r[RI_I_MAX[4:0]] <= I_MAX_RST;
      rd_data_out <= 16'h0000;
    end else begin
      for (int i = 0; i < 20; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      rd_data_out <= rd_nxt;
    end
  end

  // ****************************************************************
  // sensing and estimates
  // ****************************************************************
  logic gate_nxt, cs_low_r, cs_low_nxt, bus_valid_r, bus_valid_nxt;
  logic on_end;
  logic [28:0] bus_prod;
  logic [31:0] pout_prod;
  logic [15:0] pout;
  logic [27:0] ntc_num;
  logic [11:0] ntc_den;
  logic [27:0] ntc_quo;
  logic [15:0] bus_diff;

  assign on_end = gate_out && !gate_nxt;
  // widen before multiplying so the product keeps its upper bits
  assign bus_prod = 29'({1'b0, zcd_clamp_in} + ZCD_CLAMP_OFS) *
                    29'(ZCD_BUS_GAIN);
  assign pout_prod = vout_est_in * iout_calc_in;
  assign pout = pout_prod[31:16];
  assign ntc_num = 28'(ntc_volt_in) * 28'(NTC_PULLUP_OHM);
  assign ntc_den = NTC_VREF_CODE - ntc_volt_in;
  assign ntc_quo = (ntc_den == 12'h000) ? '1 : ntc_num / ntc_den;
  assign bus_diff = (bus_fb_r > bus_sense_in) ? bus_fb_r - bus_sense_in :
                    bus_sense_in - bus_fb_r;

  always_comb begin
    bus_fb_nxt = bus_fb_r;
    bus_valid_nxt = bus_valid_r;
    cs_low_nxt = cs_low_r;
    // clamp current and sense taken as the gate turns off
    if (on_end) begin
      bus_fb_nxt = bus_prod[23:8];
      bus_valid_nxt = 1'b1;
      cs_low_nxt = cs_sample_in < CS_SHORT_LIMIT_CODE;
    end
    if (state_r == ST_IDLE || state_r == ST_FAULT) begin
      bus_valid_nxt = 1'b0;
      cs_low_nxt = 1'b0;
    end
    // resistance = v * pull-up / (vref - v), saturating
    r_ntc_nxt = (ntc_quo > 28'h000ffff) ? 16'hffff : ntc_quo[15:0];
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_fb_r <= 16'h0000;
      bus_valid_r <= 1'b0;
      cs_low_r <= 1'b0;
      r_ntc_r <= 16'hffff;
    end else begin
      bus_fb_r <= bus_fb_nxt;
      bus_valid_r <= bus_valid_nxt;
      cs_low_r <= cs_low_nxt;
      r_ntc_r <= r_ntc_nxt;
    end
  end

  // ****************************************************************
  // protection monitors
  // ****************************************************************
  logic switching, in_run, in_burst;
  logic [6:0] mon_cond, mon_trip;
  logic [15:0] mon_limit [7];

  assign switching = state_r == ST_SOFT || state_r == ST_CHARGE ||
                     state_r == ST_RUN;
  assign in_run = state_r == ST_RUN;
  assign in_burst = in_run && mode_in == BURST_MODE;

  always_comb begin
    // pull-up drives an open pin to full scale
    mon_cond[0] = switching && (cs_sample_in >= cfg_r[RI_FINAL_LIMIT[4:0]]
                  [11:0] || cs_sample_in == 12'hfff);
    mon_cond[1] = in_run && !in_burst &&
                  vout_est_in < cfg_r[RI_UV_THR[4:0]];
    mon_cond[2] = switching && !in_burst &&
                  vout_est_in > cfg_r[RI_OV_THR[4:0]];
    mon_cond[3] = in_run && iout_calc_in > cfg_r[RI_OC_THR[4:0]];
    mon_cond[4] = in_run && pout > cfg_r[RI_OP_THR[4:0]];
    mon_cond[5] = switching && cs_low_r;
    mon_cond[6] = switching && bus_valid_r &&
                  bus_diff > cfg_r[RI_BUS_TOL[4:0]];
    mon_limit[0] = PRI_OCP_BLANK_CYC;
    mon_limit[1] = cfg_r[RI_UV_BLANK[4:0]];
    mon_limit[2] = cfg_r[RI_OV_BLANK[4:0]];
    mon_limit[3] = cfg_r[RI_OC_BLANK[4:0]];
    mon_limit[4] = cfg_r[RI_OP_BLANK[4:0]];
    mon_limit[5] = cfg_r[RI_STEP_DUR[4:0]];
    mon_limit[6] = BUS_CHECK_BLANK_CYC;
  end

  for (genvar g = 0; g < 7; g++) begin : g_mon
    fbsp_blank_timer #(.W(16)) u_tmr (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .cond_in(mon_cond[g]),
      .limit_in(mon_limit[g]),
      .trip_out(mon_trip[g])
    );
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic [15:0] sw_cnt_r, sw_cnt_nxt, step_cnt_r, step_cnt_nxt;
  logic [15:0] climit_r, climit_nxt;
  logic [25:0] to_cnt_r, to_cnt_nxt, to_limit;
  logic timeout_hit, start_ok;
  logic [16:0] tgt_up;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  assign to_limit = {cfg_r[RI_TIMEOUT[4:0]], 10'h000};
  assign start_ok = vout_est_in >= cfg_r[RI_START_UV[4:0]];
  // timeout runs from first switching until hand-over
  assign timeout_hit = (state_r == ST_SOFT || state_r == ST_CHARGE) &&
                       to_cnt_r >= to_limit && !start_ok;
  assign tgt_up = {1'b0, target_r} + {1'b0, DERATE_STEP};

  always_comb begin
    flt_set = '0;
    flt_set.pri_ocp = mon_trip[0];
    flt_set.out_uv = mon_trip[1] || timeout_hit;
    flt_set.out_ov = mon_trip[2];
    flt_set.out_oc = mon_trip[3];
    flt_set.out_op = mon_trip[4];
    flt_set.cs_short = mon_trip[5];
    flt_set.continuous_conduction = in_run && mode_in == CONTINUOUS_CONDUCTION;
    flt_set.bus_mismatch = mon_trip[6];
    flt_set.ext_ot = in_run && target_r <= cfg_r[RI_I_MIN[4:0]] &&
                     r_ntc_r < cfg_r[RI_NTC_CRIT[4:0]];
    // a fault raised in the clearing cycle survives the clear
    flt_nxt = (flt_clear ? '0 : flt_r) | flt_set;
  end

  always_comb begin
    state_nxt = state_r;
    sw_cnt_nxt = sw_cnt_r;
    step_cnt_nxt = step_cnt_r;
    climit_nxt = climit_r;
    to_cnt_nxt = (to_cnt_r != '1) ? to_cnt_r + 1'b1 : to_cnt_r;
    gate_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        to_cnt_nxt = '0;
        sw_cnt_nxt = '0;
        step_cnt_nxt = '0;
        climit_nxt = CS_STEP;
        if (cfg_r[RI_CTRL[4:0]][CTRL_EN_BIT]) begin
          state_nxt = ST_SOFT;
        end
      end
      ST_SOFT, ST_CHARGE: begin
        // fixed period switching, cycle-by-cycle limit
        sw_cnt_nxt = (sw_cnt_r + 1'b1 >= cfg_r[RI_SW_PERIOD[4:0]]) ?
                     16'h0000 : sw_cnt_r + 1'b1;
        gate_nxt = (sw_cnt_nxt == 16'h0000) ||
                   (gate_out && {4'h0, cs_sample_in} < climit_r);
        if (state_r == ST_SOFT) begin
          step_cnt_nxt = step_cnt_r + 1'b1;
          if (step_cnt_r + 1'b1 >= cfg_r[RI_STEP_DUR[4:0]]) begin
            step_cnt_nxt = '0;
            if (climit_r + CS_STEP >= cfg_r[RI_FINAL_LIMIT[4:0]]) begin
              climit_nxt = cfg_r[RI_FINAL_LIMIT[4:0]];
              state_nxt = ST_CHARGE;
            end else begin
              climit_nxt = climit_r + CS_STEP;
            end
          end
        end else if (start_ok) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        gate_nxt = loop_gate_in;
      end
      ST_FAULT: begin
        if (flt_r == '0 && !flt_clear) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_FAULT;
      end
    endcase
    if (!cfg_r[RI_CTRL[4:0]][CTRL_EN_BIT] && state_r != ST_FAULT) begin
      state_nxt = ST_IDLE;
      gate_nxt = 1'b0;
    end
    if (flt_set != '0) begin
      state_nxt = ST_FAULT;
      gate_nxt = 1'b0;
    end
  end

  always_comb begin
    // walk the target toward min when hot, toward max when cool
    target_nxt = target_r;
    if (target_r > cfg_r[RI_I_MAX[4:0]]) begin
      target_nxt = cfg_r[RI_I_MAX[4:0]];
    end else if (tick_r) begin
      if (r_ntc_r < cfg_r[RI_NTC_HOT[4:0]]) begin
        target_nxt = (target_r >= cfg_r[RI_I_MIN[4:0]] + DERATE_STEP) ?
                     target_r - DERATE_STEP : cfg_r[RI_I_MIN[4:0]];
      end else begin
        target_nxt = (tgt_up < {1'b0, cfg_r[RI_I_MAX[4:0]]}) ?
                     tgt_up[15:0] : cfg_r[RI_I_MAX[4:0]];
      end
    end
  end

  always_comb begin
    tick_nxt = tick_cnt_r >= 32'(DERATE_TICK - 1);
    tick_cnt_nxt = tick_nxt ? 32'h0000_0000 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      flt_r <= '0;
      sw_cnt_r <= 16'h0000;
      step_cnt_r <= 16'h0000;
      climit_r <= CS_STEP;
      to_cnt_r <= '0;
      target_r <= I_MAX_RST;
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      gate_out <= 1'b0;
      cur_limit_out <= 16'h0000;
      loop_enable_out <= 1'b0;
      loop_start_out <= '0;
      gate_drive_out <= '0;
      current_target_out <= I_MAX_RST;
      fault_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      flt_r <= flt_nxt;
      sw_cnt_r <= sw_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      climit_r <= climit_nxt;
      to_cnt_r <= to_cnt_nxt;
      target_r <= target_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      gate_out <= gate_nxt;
      cur_limit_out <= climit_nxt;
      loop_enable_out <= state_nxt == ST_RUN;
      loop_start_out <= '0;
      gate_drive_out <=
        fbsp_gate_drive_s'(cfg_r[RI_GATE_DRV[4:0]][7:0]);
      current_target_out <= target_nxt;
      fault_out <= flt_nxt != '0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_charged;
    state_r == ST_CHARGE && start_ok && flt_set == '0 &&
    cfg_r[RI_CTRL[4:0]][CTRL_EN_BIT];
  endsequence
  sequence s_loop_up;
    state_r == ST_RUN ##0 loop_enable_out && loop_start_out == '0;
  endsequence
  a_soft_limit_cap: assert property (state_r == ST_SOFT |->
    climit_r <= cfg_r[RI_FINAL_LIMIT[4:0]] || climit_r == CS_STEP)
    else $error("soft start limit above final");
  a_handover_loop: assert property (s_charged |=> s_loop_up)
    else $error("hand-over to loop missing");
  a_ocp_trip: assert property (mon_trip[0] |=> flt_r.pri_ocp &&
    !gate_out && fault_out) else $error("primary overcurrent lost");
  a_uv_burst_quiet: assert property (in_burst |-> !mon_cond[1])
    else $error("undervoltage checked in burst");
  a_ov_burst_quiet: assert property (in_burst |-> !mon_cond[2])
    else $error("overvoltage checked in burst");
  a_ccm_fault: assert property (in_run &&
    mode_in == CONTINUOUS_CONDUCTION |=> state_r == ST_FAULT && flt_r.continuous_conduction)
    else $error("continuous conduction not caught");
  a_timeout_uv: assert property (timeout_hit |=> flt_r.out_uv)
    else $error("startup timeout not flagged");
  a_set_beats_clr: assert property (flt_clear && flt_set.out_ov |=>
    flt_r.out_ov) else $error("fault lost to clear");
  a_target_bounds: assert property (tick_r &&
    cfg_r[RI_I_MIN[4:0]] <= cfg_r[RI_I_MAX[4:0]] &&
    target_r >= cfg_r[RI_I_MIN[4:0]] && target_r <= cfg_r[RI_I_MAX[4:0]]
    |=> target_r >= cfg_r[RI_I_MIN[4:0]]) else $error("target below min");
  a_fault_gate_off: assert property (state_r == ST_FAULT |->
    !gate_out) else $error("gate on in fault");
endmodule

// ==== fbsp_stage_model.sv ====
// Purpose: behavioural flyback power stage at the sense pins
// Assumes: one digitised sense sample per clock
// Notes: output voltage rises one code per gate pulse
module fbsp_stage_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic gate_in,
  input wire logic vout_hi_in,
  input wire logic cs_open_in,
  output logic [11:0] cs_sample_out,
  output logic [15:0] vout_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ramp_r;
  logic [15:0] vout_r;
  logic gate_r;
  // ****
  // primary ramp and output charge
  // ****
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_r <= 12'h000;
      vout_r <= 16'h0000;
      gate_r <= 1'b0;
    end else begin
      ramp_r <= gate_in ? ramp_r + 12'h008 : 12'h000;
      gate_r <= gate_in;
      if (gate_in && !gate_r) begin
        vout_r <= vout_r + 16'h0001;
      end
    end
  end
  // off level stays above the short limit, so no false short trip
  assign cs_sample_out = cs_open_in ? 12'hfff : // open pin
    (gate_in ? 12'h0c0 + ramp_r : 12'h0a0);
  assign vout_out = vout_hi_in ? 16'hf000 : vout_r;
endmodule

// ==== fbsp_top_test.sv ====
// Purpose: self-checking bench for the flyback supervisor
// Assumes: register port with read data one cycle after the strobe
// Notes: zcd, bus, iout and ntc inputs held constant
module fbsp_top_test import fbsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, loop_gate = 1'b0;
  logic vout_hi = 1'b0, cs_open = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] mode = 2'h0;
  logic [15:0] rd_data, cur_lim, target, vout;
  logic [11:0] cs;
  logic gate, loop_en, fault;
  fbsp_loop_start_s lstart;
  fbsp_gate_drive_s gdrv;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  fbsp_top #(.DERATE_TICK(8)) dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .cs_sample_in(cs), .zcd_clamp_in(12'h100), .bus_sense_in(16'h1000),
    .vout_est_in(vout), .iout_calc_in(16'h0000), .ntc_volt_in(12'h800),
    .mode_in(mode), .loop_gate_in(loop_gate), .gate_out(gate),
    .cur_limit_out(cur_lim), .loop_enable_out(loop_en),
    .loop_start_out(lstart), .gate_drive_out(gdrv),
    .current_target_out(target), .fault_out(fault));
  fbsp_stage_model stage (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .gate_in(gate), .vout_hi_in(vout_hi), .cs_open_in(cs_open),
    .cs_sample_out(cs), .vout_out(vout));
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // ****
  // shared tasks
  // ****
  task chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [5:0] i, logic [15:0] d);
    @(posedge clk_sys_in);
    wr_en <= 1'b1;
    addr <= {i, 2'b00};
    wdata <= d;
    @(posedge clk_sys_in);
    wr_en <= 1'b0;
  endtask
  task rd(string n, logic [5:0] i, logic [15:0] e);
    @(posedge clk_sys_in);
    rd_en <= 1'b1;
    addr <= {i, 2'b00};
    @(posedge clk_sys_in);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
  endtask
  task cyc_n(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task wait_run();
    for (int k = 0; k < 3000 && loop_en !== 1'b1; k++) cyc_n(1);
    chk("loop_enable", 16'h0001, {15'h0, loop_en});
  endtask
  // holds one fault source for n sampled cycles, then releases it
  task stress(bit oc, logic [1:0] m, int n);
    @(posedge clk_sys_in);
    mode <= m;
    if (oc) cs_open <= 1'b1;
    else vout_hi <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    cs_open <= 1'b0;
    vout_hi <= 1'b0;
    cyc_n(3);
  endtask
  task restart();
    wr(RI_CTRL, 16'h0003);
    wait_run();
  endtask
  task end_sim();
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task t_reset();
    chk("target", 16'h8000, target);
    rd("sw_period", RI_SW_PERIOD, 16'h0190);
    rd("step_dur", RI_STEP_DUR, 16'h0fa0);
    rd("i_max", RI_I_MAX, 16'h8000);
    rd("status", RI_STATUS, 16'h0000);
    rd("unmapped", 6'h18, 16'h0000);
  endtask
  task t_start();
    int k;
    wr(RI_SW_PERIOD, 16'h0010);
    wr(RI_STEP_DUR, 16'h0008);
    wr(RI_FINAL_LIMIT, 16'h0100);
    wr(RI_START_UV, 16'h0010);
    wr(RI_OV_THR, 16'h8000);
    wr(RI_TIMEOUT, 16'h0001);
    wr(RI_OV_BLANK, 16'h0005);
    wr(RI_BUS_TOL, 16'hffff);
    wr(RI_GATE_DRV, 16'h005a);
    cyc_n(1);
    chk("gate_drive", 16'h005a, {8'h0, gdrv});
    wr(RI_CTRL, 16'h0001);
    cyc_n(1);
    chk("limit_first", 16'h0010, cur_lim);
    cyc_n(7);
    chk("limit_hold", 16'h0010, cur_lim);
    cyc_n(1);
    chk("limit_step", 16'h0020, cur_lim);
    for (k = 0; k < 20 && gate !== 1'b1; k++) cyc_n(1);
    chk("gate_on", 16'h0001, {15'h0, gate});
    cyc_n(1);
    chk("gate_cut", 16'h0000, {15'h0, gate});
    wait_run();
    chk("loop_start", 16'h0000, {4'h0, lstart});
    rd("status_run", RI_STATUS, 16'h0400);
  endtask
  task t_ccm();
    @(posedge clk_sys_in);
    mode <= 2'h3;
    @(posedge clk_sys_in);
    mode <= 2'h0;
    cyc_n(2);
    chk("fault_ccm", 16'h0001, {15'h0, fault});
    rd("status_ccm", RI_STATUS, 16'h0c40);
    restart();
  endtask
  task t_ov();
    stress(1'b0, 2'h1, 5);
    chk("ov_short", 16'h0000, {15'h0, fault});
    stress(1'b0, 2'h2, 20);
    chk("ov_burst", 16'h0000, {15'h0, fault});
    // clear lands on the trip cycle: the new flag must survive it
    fork
      stress(1'b0, 2'h1, 9);
      begin
        repeat (6) @(posedge clk_sys_in);
        wr(RI_CTRL, 16'h0003);
      end
    join
    chk("ov_trip", 16'h0001, {15'h0, fault});
    rd("status_ov", RI_STATUS, 16'h0c04);
    restart();
  endtask
  task t_derate();
    wr(RI_I_MIN, 16'h7ff0);
    wr(RI_NTC_HOT, 16'hffff);
    cyc_n(40);
    chk("target_min", 16'h7ff0, target);
    rd("ntc_res", RI_NTC_RES, 16'h2714);
    wr(RI_NTC_CRIT, 16'hffff);
    cyc_n(2);
    chk("fault_ot", 16'h0001, {15'h0, fault});
    rd("status_ot", RI_STATUS, 16'h0d00);
    wr(RI_NTC_CRIT, 16'h0000);
    wr(RI_NTC_HOT, 16'h0000);
    cyc_n(40);
    chk("target_max", 16'h8000, target);
    restart();
  endtask
  task t_ocp();
    stress(1'b1, 2'h0, 10);
    chk("ocp_short", 16'h0000, {15'h0, fault});
    stress(1'b1, 2'h0, 14);
    chk("ocp_trip", 16'h0001, {15'h0, fault});
    rd("status_ocp", RI_STATUS, 16'h0c01);
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_start();
    t_ccm();
    t_ov();
    t_derate();
    t_ocp();
    end_sim();
  end
endmodule
